/* isr_target_rx.sv */
// I2C target receive path with address hold, data hold and 10-bit addressing.
// Overview of operation
// - Address or data hold raises an interrupt and stretches SCL after the eighth fall.
// - Start sets start-seen; interrupt flag only when start interrupts are enabled.
// - Hold mode matching write address sets flag, clears release bit, holds SCL.
// - Acknowledge-time bit shows whether an interrupt came before the acknowledge.
// - Reading the receive buffer clears buffer-full for address and data bytes.
// - Hold mode drives the software-chosen acknowledge value during the acknowledge slot.
// - Software setting the release bit lets SCL go.
// - Ninth fall after an ACK sets the flag; after a NACK only a 10-bit low byte sets it.
// - Stretch enable holds SCL low after the ACK of each 7-bit address byte and each data byte.
// - Data hold sets flag and clears release bit at each data byte's eighth fall unless buffer-full or overflow is set.
// - Reception ends on a NACK or a Stop; Stop sets stop-seen.
// - 10-bit mode sets update-address on a matching high byte with write direction.
// - After the high byte, SCL stays low until software writes the own address.
// - Low byte mismatch still sets flag and update-address, not buffer-full, release unchanged.
// - Each acknowledged data byte is eight bits plus acknowledge, then the flag is set.
// - With stretch enable hardware clears release bit; software sets it to release.
// - 10-bit hold modes stretch as 7-bit ones, plus the update-address handshake.
// - An own-address write clears the update-address flag unless hardware sets it in the same cycle.
// - Buffer-full or overflow already set means overflow and no acknowledge.
// - 10-bit first byte compares against 11110, own bits 2 and 1, then zero.
// - 7-bit matching ignores the least significant received bit.
`timescale 1ns/100ps
`default_nettype none
module isr_target_rx
	import isr_pkg::*;
(
	input  wire logic       mclk_in,                 // System clock.
	input  wire logic       rst_b_in,                // Synchronous reset, active low.
	input  wire logic       link_clk_in,             // Link sampling clock.
	input  wire logic       scl_in,                  // SCL pin level.
	input  wire logic       sda_in,                  // SDA pin level.
	output logic            scl_out,                 // SCL drive value.
	output logic            scl_oe_out,              // SCL drive enable.
	output logic            sda_out,                 // SDA drive value.
	output logic            sda_oe_out,              // SDA drive enable.
	input  wire logic       address_hold_enable_in,  // Hold before address acknowledge.
	input  wire logic       data_hold_enable_in,     // Hold before data acknowledge.
	input  wire logic       stretch_enable_in,       // Stretch after 7-bit address and data ACKs.
	input  wire logic       ten_bit_mode_in,         // 10-bit addressing.
	input  wire logic       start_irq_enable_in,     // Flag on Start.
	input  wire logic       stop_irq_enable_in,      // Flag on Stop.
	input  wire logic       ack_value_select_in,     // Acknowledge value, 1 is NACK.
	input  wire logic       irq_flag_clear_in,       // Clear the interrupt flag.
	input  wire logic       clock_release_set_in,    // Set the release bit.
	input  wire logic       buffer_read_in,          // Receive buffer read strobe.
	input  wire logic       overflow_clear_in,       // Clear the overflow flag.
	input  wire logic       own_address_write_in,    // Own address write strobe.
	input  wire logic [7:0] own_address_data_in,     // Own address write data.
	output logic [7:0]      receive_buffer_reg_out,  // Received byte.
	output logic            buffer_full_flag_out,    // Buffer holds an unread byte.
	output logic            receive_overflow_flag_out, // Byte arrived while full.
	output logic            serial_port_irq_flag_out, // Interrupt flag.
	output logic            clock_release_bit_out,   // Release bit.
	output logic            ack_time_status_out,     // In acknowledge time.
	output logic            update_address_flag_out, // Own address must be rewritten.
	output logic            start_seen_out,          // Last condition was Start.
	output logic            stop_seen_out,           // Last condition was Stop.
	output logic            read_write_out,          // Direction of last address.
	output logic [7:0]      own_address_reg_out      // Own address register.
);

	typedef struct packed {
		isr_state_t state;
		isr_kind_t  kind;
		logic [3:0] cnt;
		logic [7:0] shreg;
		logic [7:0] rxbuf;
		logic [7:0] own;
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic       bf;
		logic       ov;
		logic       irq;
		logic       clock_release_bit;
		logic       ackt;
		logic       ua;
		logic       ua_hold;
		logic       start_seen;
		logic       stop_seen;
		logic       rw;
		logic       nack;
		logic       scl_hold;
		logic       sda_low;
	} isr_q_t;

	isr_q_t q;
	isr_q_t next_q;

	logic scl_level;
	logic sda_level;

	isr_pad u_pad (
		.link_clk_in   (link_clk_in),
		.rst_b_in      (rst_b_in),
		.scl_in        (scl_in),
		.sda_in        (sda_in),
		.scl_hold_in   (q.scl_hold),
		.sda_low_in    (q.sda_low),
		.scl_level_out (scl_level),
		.sda_level_out (sda_level),
		.scl_out       (scl_out),
		.scl_oe_out    (scl_oe_out),
		.sda_out       (sda_out),
		.sda_oe_out    (sda_oe_out)
	);

	// Address comparison for the first byte and the 10-bit low byte.
	function automatic logic addr_match(
		input isr_kind_t  kind,
		input logic       ten,
		input logic [7:0] rx,
		input logic [7:0] own
	);
		logic ok;
		ok = 1'b1;
		case (kind)
			ISR_KIND_ADDR: begin
				if (ten) begin
					ok = (rx[ISR_TEN_PFX_MSB:ISR_TEN_PFX_LSB] == ISR_TEN_PREFIX) &&
					     (rx[ISR_TEN_HI_MSB:ISR_TEN_HI_LSB] == own[ISR_TEN_HI_MSB:ISR_TEN_HI_LSB]);
				end else begin
					ok = (rx[ISR_SEVEN_MSB:ISR_SEVEN_LSB] == own[ISR_SEVEN_MSB:ISR_SEVEN_LSB]);
				end
			end
			ISR_KIND_LOW: begin
				ok = (rx == own);
			end
			default: begin
				ok = 1'b1;
			end
		endcase
		return ok;
	endfunction

	logic scl_now;
	logic scl_prev;
	logic sda_now;
	logic sda_prev;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic hold_en;
	logic match;
	logic ovf;

	assign scl_now   = q.scl_s[1];
	assign scl_prev  = q.scl_s[2];
	assign sda_now   = q.sda_s[1];
	assign sda_prev  = q.sda_s[2];
	assign scl_rise  = scl_now && !scl_prev;
	assign scl_fall  = !scl_now && scl_prev;
	assign start_det = scl_now && scl_prev && sda_prev && !sda_now;
	assign stop_det  = scl_now && scl_prev && !sda_prev && sda_now;
	assign hold_en   = (q.kind == ISR_KIND_DATA) ? data_hold_enable_in : address_hold_enable_in;
	assign match     = addr_match(q.kind, ten_bit_mode_in, q.shreg, q.own);
	assign ovf       = q.bf || q.ov;

	always_comb begin
		next_q = q;
		// Stage 0 of each line synchroniser feeds only stage 1.
		next_q.scl_s = {q.scl_s[1:0], scl_level};
		next_q.sda_s = {q.sda_s[1:0], sda_level};

		// Software actions first, so that a hardware set in the same cycle wins.
		if (irq_flag_clear_in) begin
			next_q.irq = 1'b0;
		end
		if (buffer_read_in) begin
			next_q.bf = 1'b0;
		end
		if (overflow_clear_in) begin
			next_q.ov = 1'b0;
		end
		if (clock_release_set_in) begin
			next_q.clock_release_bit = 1'b1;
		end
		if (own_address_write_in) begin
			next_q.own     = own_address_data_in;
			next_q.ua      = 1'b0;
			next_q.ua_hold = 1'b0;
		end

		case (q.state)
			ISR_ST_IDLE: begin
				next_q.cnt = ISR_CNT_RST;
			end
			ISR_ST_SHIFT: begin
				if (scl_rise && (q.cnt < ISR_EIGHTH_EDGE)) begin
					next_q.shreg = {q.shreg[6:0], sda_now};
					next_q.cnt   = q.cnt + 4'h1;
				end
				if (scl_fall && (q.cnt == ISR_EIGHTH_EDGE)) begin
					if (q.kind == ISR_KIND_ADDR) begin
						next_q.rw = q.shreg[ISR_RW_POS];
					end
					if ((q.kind != ISR_KIND_LOW) && (!match || ((q.kind == ISR_KIND_ADDR) && q.shreg[ISR_RW_POS]))) begin
						// Not addressed, or a read request: go quiet.
						next_q.state = ISR_ST_IDLE;
					end else if (!match) begin
						// Low byte mismatch: no buffer, release bit untouched.
						next_q.nack  = 1'b1;
						next_q.state = ISR_ST_ACK;
					end else if (ovf) begin
						next_q.ov    = 1'b1;
						next_q.nack  = 1'b1;
						next_q.state = ISR_ST_ACK;
					end else begin
						next_q.rxbuf = q.shreg;
						next_q.bf    = 1'b1;
						if (hold_en) begin
							next_q.irq   = 1'b1;
							next_q.clock_release_bit   = 1'b0;
							next_q.ackt  = 1'b1;
							next_q.state = ISR_ST_HOLD8;
						end else begin
							next_q.nack  = 1'b0;
							next_q.state = ISR_ST_ACK;
						end
					end
				end
			end
			ISR_ST_HOLD8: begin
				// SCL stays low here until software sets the release bit.
				if (q.clock_release_bit) begin
					next_q.nack  = ack_value_select_in;
					next_q.state = ISR_ST_ACK;
				end
			end
			ISR_ST_ACK: begin
				if (scl_rise && (q.cnt == ISR_EIGHTH_EDGE)) begin
					next_q.cnt = ISR_NINTH_EDGE;
				end
				if (scl_fall && (q.cnt == ISR_NINTH_EDGE)) begin
					next_q.cnt  = ISR_CNT_RST;
					next_q.ackt = 1'b0;
					if (q.kind == ISR_KIND_LOW) begin
						next_q.irq     = 1'b1;
						next_q.ua      = 1'b1;
						next_q.ua_hold = 1'b1;
					end
					if (q.nack) begin
						next_q.state = ISR_ST_IDLE;
					end else begin
						next_q.irq = 1'b1;
						if ((q.kind == ISR_KIND_ADDR) && ten_bit_mode_in) begin
							next_q.ua      = 1'b1;
							next_q.ua_hold = 1'b1;
							next_q.kind    = ISR_KIND_LOW;
							next_q.state   = ISR_ST_SHIFT;
						end else if (q.kind == ISR_KIND_LOW) begin
							next_q.kind  = ISR_KIND_DATA;
							next_q.state = ISR_ST_SHIFT;
						end else begin
							next_q.kind = ISR_KIND_DATA;
							if (stretch_enable_in) begin
								next_q.clock_release_bit   = 1'b0;
								next_q.state = ISR_ST_HOLD9;
							end else begin
								next_q.state = ISR_ST_SHIFT;
							end
						end
					end
				end
			end
			ISR_ST_HOLD9: begin
				if (q.clock_release_bit) begin
					next_q.state = ISR_ST_SHIFT;
				end
			end
			default: begin
				next_q.state = ISR_ST_IDLE;
			end
		endcase

		// Bus conditions override the byte sequence.
		if (start_det) begin
			next_q.start_seen = 1'b1;
			next_q.stop_seen  = 1'b0;
			if (start_irq_enable_in) begin
				next_q.irq = 1'b1;
			end
			next_q.state = ISR_ST_SHIFT;
			next_q.kind  = ISR_KIND_ADDR;
			next_q.cnt   = ISR_CNT_RST;
			next_q.nack  = 1'b0;
			next_q.ackt  = 1'b0;
		end else if (stop_det) begin
			next_q.stop_seen  = 1'b1;
			next_q.start_seen = 1'b0;
			if (stop_irq_enable_in) begin
				next_q.irq = 1'b1;
			end
			next_q.state = ISR_ST_IDLE;
			next_q.ackt  = 1'b0;
		end

		// Pin requests are registered so the link domain samples clean levels.
		next_q.scl_hold = (next_q.state == ISR_ST_HOLD8) ||
		                  (next_q.state == ISR_ST_HOLD9) ||
		                  next_q.ua_hold;
		next_q.sda_low  = (next_q.state == ISR_ST_ACK) && !next_q.nack;
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			q            <= '0;
			q.state      <= ISR_ST_IDLE;
			q.kind       <= ISR_KIND_ADDR;
			q.cnt        <= ISR_CNT_RST;
			q.own        <= ISR_OWN_ADDR_RST;
			q.rxbuf      <= ISR_RXBUF_RST;
			q.clock_release_bit        <= ISR_CKP_RST;
			q.scl_s      <= ISR_LINE_RST;
			q.sda_s      <= ISR_LINE_RST;
			q.bf         <= ISR_FLAG_RST;
			q.ov         <= ISR_FLAG_RST;
			q.irq        <= ISR_FLAG_RST;
			q.ua         <= ISR_FLAG_RST;
			q.start_seen <= ISR_FLAG_RST;
			q.stop_seen  <= ISR_FLAG_RST;
		end else begin
			q <= next_q;
		end
	end

	assign receive_buffer_reg_out    = q.rxbuf;
	assign buffer_full_flag_out      = q.bf;
	assign receive_overflow_flag_out = q.ov;
	assign serial_port_irq_flag_out  = q.irq;
	assign clock_release_bit_out     = q.clock_release_bit;
	assign ack_time_status_out       = q.ackt;
	assign update_address_flag_out   = q.ua;
	assign start_seen_out            = q.start_seen;
	assign stop_seen_out             = q.stop_seen;
	assign read_write_out            = q.rw;
	assign own_address_reg_out       = q.own;

endmodule
`default_nettype wire

/* isr_pkg.sv */
// Shared constants and types of the I2C target receive path.
package isr_pkg;

	// Rising-edge counts that mark the data bits and the acknowledge bit of a byte.
	localparam logic [3:0] ISR_EIGHTH_EDGE = 4'h8;
	localparam logic [3:0] ISR_NINTH_EDGE  = 4'h9;
	localparam logic [3:0] ISR_CNT_RST     = 4'h0;

	// First byte of a 10-bit address: 1 1 1 1 0 A9 A8 0.
	localparam logic [4:0]  ISR_TEN_PREFIX  = 5'h1e;
	localparam int unsigned ISR_TEN_PFX_MSB = 7;
	localparam int unsigned ISR_TEN_PFX_LSB = 3;
	localparam int unsigned ISR_TEN_HI_MSB  = 2;
	localparam int unsigned ISR_TEN_HI_LSB  = 1;
	localparam int unsigned ISR_SEVEN_MSB   = 7;
	localparam int unsigned ISR_SEVEN_LSB   = 1;
	localparam int unsigned ISR_RW_POS      = 0;

	// Reset values.
	localparam logic [7:0] ISR_OWN_ADDR_RST = 8'h00;
	localparam logic [7:0] ISR_RXBUF_RST    = 8'h00;
	localparam logic       ISR_CKP_RST      = 1'b1;
	localparam logic       ISR_FLAG_RST     = 1'b0;
	localparam logic [2:0] ISR_LINE_RST     = 3'h7;

	typedef enum logic [2:0] {
		ISR_ST_IDLE  = 3'b000,
		ISR_ST_SHIFT = 3'b001,
		ISR_ST_HOLD8 = 3'b010,
		ISR_ST_ACK   = 3'b011,
		ISR_ST_HOLD9 = 3'b100
	} isr_state_t;

	typedef enum logic [1:0] {
		ISR_KIND_ADDR = 2'h0,
		ISR_KIND_LOW  = 2'h1,
		ISR_KIND_DATA = 2'h2
	} isr_kind_t;

endpackage

/* isr_pad.sv */
// Link-clock pad stage: samples SCL and SDA and drives their open-drain enables.
`timescale 1ns/100ps
`default_nettype none
module isr_pad (
	input  wire logic link_clk_in,   // Link sampling clock.
	input  wire logic rst_b_in,      // System reset, active low.
	input  wire logic scl_in,        // SCL pin level.
	input  wire logic sda_in,        // SDA pin level.
	input  wire logic scl_hold_in,   // Hold SCL low, system domain.
	input  wire logic sda_low_in,    // Pull SDA low, system domain.
	output logic      scl_level_out, // Sampled SCL level.
	output logic      sda_level_out, // Sampled SDA level.
	output logic      scl_out,       // SCL drive value.
	output logic      scl_oe_out,    // SCL drive enable.
	output logic      sda_out,       // SDA drive value.
	output logic      sda_oe_out     // SDA drive enable.
);

	typedef struct packed {
		logic [1:0] rst;
		logic [1:0] scl;
		logic [1:0] sda;
		logic [1:0] hold;
		logic [1:0] low;
	} isr_pad_q_t;

	isr_pad_q_t q;
	isr_pad_q_t next_q;

	// Each field is a two-stage synchroniser; stage 0 feeds only stage 1.
	always_comb begin
		next_q      = q;
		next_q.rst  = {q.rst[0], rst_b_in};
		next_q.scl  = {q.scl[0], scl_in};
		next_q.sda  = {q.sda[0], sda_in};
		next_q.hold = {q.hold[0], scl_hold_in};
		next_q.low  = {q.low[0], sda_low_in};
		if (!q.rst[1]) begin
			next_q.scl  = 2'h3;
			next_q.sda  = 2'h3;
			next_q.hold = 2'h0;
			next_q.low  = 2'h0;
		end
	end

	always_ff @(posedge link_clk_in) begin
		q <= next_q;
	end

	// Open-drain pins only ever pull low.
	assign scl_out       = 1'b0;
	assign sda_out       = 1'b0;
	assign scl_oe_out    = q.hold[1];
	assign sda_oe_out    = q.low[1];
	assign scl_level_out = q.scl[1];
	assign sda_level_out = q.sda[1];

endmodule
`default_nettype wire

/* isr_checker.sv */
// Concurrent checks on the ports of the I2C target receive path.
`timescale 1ns/100ps
`default_nettype none
module isr_checker (
	input wire logic       mclk_in,                   // Clock.
	input wire logic       rst_b_in,                  // Reset.
	input wire logic       scl_oe_out,                // SCL hold.
	input wire logic       own_address_write_in,      // Own write.
	input wire logic [7:0] own_address_data_in,       // Own data.
	input wire logic [7:0] own_address_reg_out,       // Own value.
	input wire logic       buffer_read_in,            // Buffer read.
	input wire logic       buffer_full_flag_out,      // Full.
	input wire logic       receive_overflow_flag_out, // Overflow.
	input wire logic       serial_port_irq_flag_out,  // Flag.
	input wire logic       clock_release_bit_out,     // Release bit.
	input wire logic       clock_release_set_in,      // Release set.
	input wire logic       update_address_flag_out,   // Update flag.
	input wire logic       ack_time_status_out,       // Ack time.
	input wire logic       address_hold_enable_in,    // Address hold.
	input wire logic       data_hold_enable_in,       // Data hold.
	input wire logic       start_seen_out,            // Start seen.
	input wire logic       start_irq_enable_in        // Start flag on.
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);
	rel_clear_flag_a: assert property ($fell(clock_release_bit_out) |-> ##[0:3] serial_port_irq_flag_out)
		else $error("release bit cleared without flag");
	rel_set_cause_a: assert property ($rose(clock_release_bit_out) |-> $past(clock_release_set_in))
		else $error("release bit set without request");
	scl_let_go_a: assert property ($rose(clock_release_bit_out) && !update_address_flag_out |-> ##[1:8] !scl_oe_out)
		else $error("clock not released");
	buf_read_a: assert property (buffer_read_in |=> !buffer_full_flag_out)
		else $error("buffer full after read");
	ua_write_a: assert property (own_address_write_in |=> !update_address_flag_out)
		else $error("update flag after own write");
	own_store_a: assert property (own_address_write_in |=> own_address_reg_out == $past(own_address_data_in))
		else $error("own address not stored");
	ack_mode_a: assert property (ack_time_status_out |-> address_hold_enable_in || data_hold_enable_in)
		else $error("ack time outside hold modes");
	ov_cause_a: assert property ($rose(receive_overflow_flag_out) |-> $past(buffer_full_flag_out))
		else $error("overflow without full buffer");
	start_quiet_a: assert property ($rose(start_seen_out) && !start_irq_enable_in |-> !$rose(serial_port_irq_flag_out))
		else $error("flag on start while disabled");
endmodule
bind isr_target_rx isr_checker isr_checker_i (.*);
`default_nettype wire

/* isr_master.sv */
// Behavioural I2C controller that drives the bus for the bench.
`timescale 1ns/100ps
`default_nettype none
module isr_master (
	input wire logic mclk_in,     // Timing reference.
	input wire logic scl_in,      // Wired SCL level.
	input wire logic sda_in,      // Wired SDA level.
	output logic     scl_low_out, // Pull SCL low.
	output logic     sda_low_out, // Pull SDA low.
	output logic     stall_out    // Stretch never ended.
);
	localparam int QTR = 10;
	initial begin
		scl_low_out = 1'h0;
		sda_low_out = 1'h0;
		stall_out = 1'h0;
	end
	task automatic gap();
		repeat (QTR) @(posedge mclk_in);
		#1;
	endtask
	// Releases SCL and waits while the target stretches it.
	task automatic rise();
		int n;
		n = 0;
		scl_low_out = 1'h0;
		while (scl_in !== 1'h1 && n < 4000) begin
			@(posedge mclk_in);
			#1;
			n++;
		end
		if (scl_in !== 1'h1) stall_out = 1'h1;
		gap();
	endtask
	task automatic start();
		sda_low_out = 1'h0;
		gap();
		rise();
		sda_low_out = 1'h1;
		gap();
		scl_low_out = 1'h1;
		gap();
	endtask
	task automatic stop();
		sda_low_out = 1'h1;
		gap();
		rise();
		sda_low_out = 1'h0;
		gap();
	endtask
	// Eight bits MSB first, then the target's acknowledge on the ninth pulse.
	task automatic xfer(input logic [7:0] d, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda_low_out = !d[i];
			gap();
			rise();
			scl_low_out = 1'h1;
			gap();
		end
		sda_low_out = 1'h0;
		gap();
		rise();
		ack = sda_in;
		scl_low_out = 1'h1;
		gap();
	endtask
endmodule
`default_nettype wire

/* isr_tb.sv */
// Self-checking bench for the I2C target receive path.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic            mclk_in = 1'h0;
	logic            link_clk = 1'h0;
	logic            rst_b_in = 1'h0;
	logic [6:0]      cfg = 7'h00;
	logic [4:0]      stb = 5'h00;
	logic [7:0]      own_d = 8'h00;
	logic            ack;
	int              fails = 0;
	int              comparisons = 0;
	wire logic       scl, sda, scl_oe, sda_oe, m_scl, m_sda, rel, bf, ov, irq, at, ua, ss, ps, rw, stall;
	wire logic [7:0] rxb, own;
	always #50 mclk_in = ~mclk_in;
	always #7.5 link_clk = ~link_clk;
	assign scl = !(scl_oe | m_scl);
	assign sda = !(sda_oe | m_sda);
	isr_target_rx isr_target_rx_i (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .link_clk_in(link_clk), .scl_in(scl),
		.sda_in(sda), .scl_out(), .scl_oe_out(scl_oe), .sda_out(), .sda_oe_out(sda_oe),
		.address_hold_enable_in(cfg[6]), .data_hold_enable_in(cfg[5]), .stretch_enable_in(cfg[4]),
		.ten_bit_mode_in(cfg[3]), .start_irq_enable_in(cfg[2]), .stop_irq_enable_in(cfg[1]),
		.ack_value_select_in(cfg[0]), .irq_flag_clear_in(stb[0]), .clock_release_set_in(stb[1]),
		.buffer_read_in(stb[2]), .overflow_clear_in(stb[3]), .own_address_write_in(stb[4]),
		.own_address_data_in(own_d), .receive_buffer_reg_out(rxb), .buffer_full_flag_out(bf),
		.receive_overflow_flag_out(ov), .serial_port_irq_flag_out(irq), .clock_release_bit_out(rel),
		.ack_time_status_out(at), .update_address_flag_out(ua), .start_seen_out(ss), .stop_seen_out(ps),
		.read_write_out(rw), .own_address_reg_out(own));
	isr_master isr_master_i (.mclk_in(mclk_in), .scl_in(scl), .sda_in(sda), .scl_low_out(m_scl),
		.sda_low_out(m_sda), .stall_out(stall));
	task automatic step();
		@(posedge mclk_in);
		#1;
	endtask
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic pulse(input int b);
		stb[b] = 1'h1;
		step();
		stb = 5'h00;
		step();
	endtask
	task automatic wr_own(input logic [7:0] d);
		own_d = d;
		pulse(4);
	endtask
	// Software side of a hold: inspect, empty the buffer, choose the acknowledge, release.
	task automatic svc(input logic av);
		int n;
		n = 0;
		while (irq !== 1'h1 && n < 2000) begin
			step();
			n++;
		end
		repeat (3) step();
		chk("hold_rel", rel, 1'h0);
		chk("hold_at", at, 1'h1);
		chk("hold_scl", scl_oe, 1'h1);
		pulse(0);
		pulse(2);
		cfg[0] = av;
		pulse(1);
	endtask
	initial begin
		repeat (12) step();
		rst_b_in = 1'h1;
		repeat (20) step();
		chk("rst_rel", rel, 1'h1);
		chk("rst_flags", {bf, ov, irq, at, ua, scl_oe, sda_oe}, 8'h00);
		chk("rst_own", own, 8'h00);
		cfg = 7'h16;
		wr_own(8'ha5);
		isr_master_i.start();
		chk("start_seen", ss, 1'h1);
		chk("start_irq", irq, 1'h1);
		pulse(0);
		isr_master_i.xfer(8'h20, ack);
		chk("miss_ack", {ack, irq}, 8'h02);
		isr_master_i.start();
		pulse(0);
		isr_master_i.xfer(8'ha4, ack);
		chk("a7_ack", {ack, rw}, 8'h00);
		chk("a7_buf", rxb, 8'ha4);
		chk("a7_flags", {bf, irq, rel}, 8'h06);
		pulse(0);
		pulse(2);
		chk("a7_read", bf, 1'h0);
		pulse(1);
		repeat (8) step();
		chk("a7_go", scl_oe, 1'h0);
		isr_master_i.xfer(8'h3c, ack);
		chk("d7_ack", ack, 1'h0);
		chk("d7_buf", rxb, 8'h3c);
		chk("d7_flags", {irq, rel}, 8'h02);
		pulse(0);
		pulse(1);
		isr_master_i.xfer(8'hc3, ack);
		chk("ov_ack", {ack, ov, irq}, 8'h06);
		chk("ov_buf", rxb, 8'h3c);
		pulse(2);
		pulse(3);
		isr_master_i.stop();
		chk("stop", {ps, irq}, 8'h03);
		pulse(0);
		cfg = 7'h60;
		isr_master_i.start();
		chk("quiet_start", irq, 1'h0);
		fork
			isr_master_i.xfer(8'ha4, ack);
			svc(1'h0);
		join
		chk("ah_ack", {ack, at, irq}, 8'h01);
		pulse(0);
		fork
			isr_master_i.xfer(8'h5e, ack);
			svc(1'h1);
		join
		chk("dh_ack", {ack, irq}, 8'h02);
		chk("dh_buf", rxb, 8'h5e);
		isr_master_i.stop();
		cfg = 7'h08;
		wr_own(8'hf6);
		isr_master_i.start();
		isr_master_i.xfer(8'hf6, ack);
		chk("hi_ack", ack, 1'h0);
		chk("hi_ua", {ua, irq, scl_oe}, 8'h07);
		pulse(2);
		wr_own(8'h5a);
		chk("lo_ua", ua, 1'h0);
		isr_master_i.xfer(8'h5a, ack);
		chk("lo_ack", ack, 1'h0);
		chk("lo_buf", rxb, 8'h5a);
		chk("lo_flags", {bf, ua}, 8'h03);
		pulse(2);
		wr_own(8'hf6);
		isr_master_i.xfer(8'h81, ack);
		chk("d10_ack", ack, 1'h0);
		chk("d10_buf", rxb, 8'h81);
		pulse(0);
		pulse(2);
		isr_master_i.start();
		isr_master_i.xfer(8'hf6, ack);
		pulse(2);
		wr_own(8'h5a);
		pulse(0);
		isr_master_i.xfer(8'h33, ack);
		chk("mm_ack", ack, 1'h1);
		chk("mm_flags", {bf, ua, irq, rel}, 8'h07);
		wr_own(8'hf6);
		isr_master_i.stop();
		chk("stall", stall, 1'h0);
		end_of_test();
	end
	initial begin
		repeat (40000) step();
		fails++;
		end_of_test();
	end
endmodule
`default_nettype wire
